/* csc_regs_pkg.sv */
package csc_regs_pkg;
    localparam int addr_width = 8;
    localparam int data_width = 32;
    // word-aligned byte addresses
    localparam logic [7:0] off_codec_buffer_base = 8'h00;
    localparam logic [7:0] off_yc_to_rgb_set_zero = 8'h04;
    localparam logic [7:0] off_yc_to_rgb_set_one = 8'h08;
    localparam logic [7:0] off_rgb_to_yc_set_zero = 8'h0c;
    localparam logic [7:0] off_rgb_to_yc_set_one = 8'h10;
    localparam logic [7:0] off_rgb_to_yc_set_two = 8'h14;
    localparam int reg_count = 6;
    localparam logic [31:0] rst_codec_buffer_base = 32'h0000_0000;
    localparam logic [31:0] rst_yc_to_rgb_set_zero = 32'h6832_cc95;
    localparam logic [31:0] rst_yc_to_rgb_set_one = 32'h0000_7102;
    localparam logic [31:0] rst_rgb_to_yc_set_zero = 32'h0132_4145;
    localparam logic [31:0] rst_rgb_to_yc_set_one = 32'h0124_5e38;
    localparam logic [31:0] rst_rgb_to_yc_set_two = 32'h0138_4a4b;
    // writable bit masks
    localparam logic [31:0] mask_all = 32'hffff_ffff;
    localparam logic [31:0] mask_yc_to_rgb_set_one = 32'h0000_71ff;
    localparam logic [31:0] mask_rgb_to_yc = 32'h01ff_ffff;
    // field positions
    localparam int coef_width = 8;
    localparam int coef_wide_width = 9;
    localparam int pos_y_offset = 12;
    localparam int pos_cr_offset = 13;
    localparam int pos_cb_offset = 14;
    localparam int pos_comp_offset = 24;
    // offset amounts
    localparam logic [7:0] offset_large = 8'h80;
    localparam logic [7:0] offset_small = 8'h10;
    localparam logic [7:0] offset_none = 8'h00;
    localparam logic [31:0] data_zero = 32'h0000_0000;
endpackage : csc_regs_pkg

/* csc_reg_if.sv */
`timescale 1ns/1ps
interface csc_reg_if;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [3:0] sel;
    logic [31:0] rdata;
    logic hit;
    modport master (output write, addr, wdata, sel, input rdata, hit);
    modport slave (input write, addr, wdata, sel, output rdata, hit);
endinterface : csc_reg_if

/* csc_word_reg.sv */
`timescale 1ns/1ps
module csc_word_reg #(
    parameter logic [31:0] reset_value = 32'h0000_0000,
    parameter logic [31:0] write_mask = 32'hffff_ffff
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_we,
    input wire logic [3:0] i_sel,
    input wire logic [31:0] i_wdata,
    output logic [31:0] o_value
);
    logic [31:0] next_value;
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_lane
            // reserved bits hold their zero
            assign next_value[lane*8 +: 8] = (i_we && i_sel[lane]) ?
                (i_wdata[lane*8 +: 8] & write_mask[lane*8 +: 8]) : o_value[lane*8 +: 8];
        end
    endgenerate

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_value <= reset_value;
        end else begin
            o_value <= next_value;
        end
    end
endmodule : csc_word_reg

/* csc_decoder.sv */
`timescale 1ns/1ps
module csc_decoder
    import csc_regs_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    csc_reg_if.slave bus,
    output logic [31:0] o_regs [reg_count]
);
    localparam logic [31:0] rst_vals [reg_count] = '{rst_codec_buffer_base,
        rst_yc_to_rgb_set_zero, rst_yc_to_rgb_set_one, rst_rgb_to_yc_set_zero,
        rst_rgb_to_yc_set_one, rst_rgb_to_yc_set_two};
    localparam logic [31:0] masks [reg_count] = '{mask_all, mask_all,
        mask_yc_to_rgb_set_one, mask_rgb_to_yc, mask_rgb_to_yc, mask_rgb_to_yc};
    localparam logic [7:0] offs [reg_count] = '{off_codec_buffer_base,
        off_yc_to_rgb_set_zero, off_yc_to_rgb_set_one, off_rgb_to_yc_set_zero,
        off_rgb_to_yc_set_one, off_rgb_to_yc_set_two};
    logic [reg_count-1:0] match;
    genvar i;
    generate
        for (i = 0; i < reg_count; i++) begin : g_reg
            assign match[i] = (bus.addr == offs[i]);
            csc_word_reg #(.reset_value(rst_vals[i]), .write_mask(masks[i])) u_reg (
                .i_core_clk(i_core_clk),
                .i_rst(i_rst),
                .i_we(bus.write && match[i]),
                .i_sel(bus.sel),
                .i_wdata(bus.wdata),
                .o_value(o_regs[i])
            );
        end
    endgenerate
    always_comb begin
        bus.rdata = data_zero;
        for (int k = 0; k < reg_count; k++) begin
            if (match[k]) begin
                bus.rdata = o_regs[k];
            end
        end
    end
    assign bus.hit = |match;
endmodule : csc_decoder

/* image_color_space_coef_regs.sv */
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
// Overview of operation
// - 32-bit codec buffer base, resets to zero
// - four 8-bit luma-to-RGB coefficients, low first
// - fifth coefficient is 9 bits, low bits
// - luma offset select gives 128 or none
// - chroma offset selects give 16 or none
// - RGB-to-luma set zero: three 8-bit coefficients
// - red offset select bit 24 gives 16
// - RGB-to-luma set one: three 8-bit coefficients
// - green offset select bit 24 gives 128
// - RGB-to-luma set two: three 8-bit coefficients
// - blue offset select bit 24 gives 128
module image_color_space_coef_regs
    import csc_regs_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [csc_regs_pkg::addr_width-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [csc_regs_pkg::data_width-1:0] i_wb_dat,
    output logic [csc_regs_pkg::data_width-1:0] o_wb_dat,
    output logic o_wb_ack,
    output logic o_wb_err,
    output logic [31:0] o_codec_buffer_base,
    output logic [7:0] o_yc_coef [5],
    output logic o_yc_coef4_msb,
    output logic [7:0] o_y_offset,
    output logic [7:0] o_cr_offset,
    output logic [7:0] o_cb_offset,
    output logic [7:0] o_rgb_coef [9],
    output logic [7:0] o_r_offset,
    output logic [7:0] o_g_offset,
    output logic [7:0] o_b_offset
);
    import csc_regs_pkg::*;

    csc_reg_if bus ();
    logic [31:0] regs [reg_count];
    logic req;

    // at most one request every other cycle; ack clears itself so a held strobe is answered again every other cycle
    assign req = i_wb_cyc && i_wb_stb && !o_wb_ack && !o_wb_err;
    assign bus.addr = i_wb_adr;
    assign bus.sel = i_wb_sel;
    assign bus.wdata = i_wb_dat;
    assign bus.write = req && i_wb_we && bus.hit;

    csc_decoder u_dec (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .bus(bus),
        .o_regs(regs)
    );

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wb_ack <= 1'b0;
            o_wb_err <= 1'b0;
            o_wb_dat <= data_zero;
        end else begin
            o_wb_ack <= req && bus.hit;
            o_wb_err <= req && !bus.hit;
            o_wb_dat <= (req && bus.hit && !i_wb_we) ? bus.rdata : data_zero;
        end
    end

    // conversion-side views, registered
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_codec_buffer_base <= rst_codec_buffer_base;
        end else begin
            o_codec_buffer_base <= regs[0];
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int k = 0; k < 5; k++) begin
                o_yc_coef[k] <= offset_none;
            end
            o_yc_coef4_msb <= 1'b0;
            o_y_offset <= offset_none;
            o_cr_offset <= offset_none;
            o_cb_offset <= offset_none;
        end else begin
            for (int k = 0; k < 4; k++) begin
                o_yc_coef[k] <= regs[1][k*coef_width +: coef_width];
            end
            o_yc_coef[4] <= regs[2][coef_width-1:0];
            o_yc_coef4_msb <= regs[2][coef_wide_width-1];
            o_y_offset <= regs[2][pos_y_offset] ? offset_large : offset_none;
            o_cr_offset <= regs[2][pos_cr_offset] ? offset_small : offset_none;
            o_cb_offset <= regs[2][pos_cb_offset] ? offset_small : offset_none;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int k = 0; k < 9; k++) begin
                o_rgb_coef[k] <= offset_none;
            end
            o_r_offset <= offset_none;
            o_g_offset <= offset_none;
            o_b_offset <= offset_none;
        end else begin
            for (int k = 0; k < 3; k++) begin
                o_rgb_coef[k] <= regs[3][k*coef_width +: coef_width];
                o_rgb_coef[k+3] <= regs[4][k*coef_width +: coef_width];
                o_rgb_coef[k+6] <= regs[5][k*coef_width +: coef_width];
            end
            o_r_offset <= regs[3][pos_comp_offset] ? offset_small : offset_none;
            o_g_offset <= regs[4][pos_comp_offset] ? offset_large : offset_none;
            o_b_offset <= regs[5][pos_comp_offset] ? offset_large : offset_none;
        end
    end

    a_ack_one_cycle: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_wb_ack |=> !o_wb_ack)
        else $error("ack held longer than one cycle");

    a_ack_after_req: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_wb_cyc && i_wb_stb && !o_wb_ack && !o_wb_err && bus.hit) |=> o_wb_ack)
        else $error("mapped request not acknowledged");

    a_base_write: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (bus.write && i_wb_adr == off_codec_buffer_base && i_wb_sel == 4'hf)
        |=> ##1 o_codec_buffer_base == $past(i_wb_dat, 2))
        else $error("base address not updated");

    a_reserved_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (regs[2] & ~mask_yc_to_rgb_set_one) == data_zero
        && (regs[3] & ~mask_rgb_to_yc) == data_zero)
        else $error("reserved bits set");

    a_y_offset: assert property (@(posedge i_core_clk) disable iff (i_rst)
        regs[2][pos_y_offset] |=> o_y_offset == offset_large)
        else $error("luma offset wrong");

    a_cr_offset: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !regs[2][pos_cr_offset] |=> o_cr_offset == offset_none)
        else $error("red chroma offset wrong");

    a_coef_wide: assert property (@(posedge i_core_clk) disable iff (i_rst)
        1'b1 |=> {o_yc_coef4_msb, o_yc_coef[4]} == $past(regs[2][coef_wide_width-1:0]))
        else $error("wide coefficient wrong");

    a_coef_pack: assert property (@(posedge i_core_clk) disable iff (i_rst)
        1'b1 |=> o_yc_coef[3] == $past(regs[1][31:24]) && o_rgb_coef[8] == $past(regs[5][23:16]))
        else $error("coefficient packing wrong");

    a_g_offset: assert property (@(posedge i_core_clk) disable iff (i_rst)
        regs[4][pos_comp_offset] |=> o_g_offset == offset_large)
        else $error("green offset wrong");

    // bus handshake
    a_err_one_cycle: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_wb_err
        |=> !o_wb_err)
        else $error("err held longer than one cycle");

    a_err_on_miss: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (req && !bus.hit)
        |=> o_wb_err && !o_wb_ack)
        else $error("unmapped request not refused");

    a_no_answer_idle: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !(i_wb_cyc && i_wb_stb)
        |=> !o_wb_ack && !o_wb_err)
        else $error("answer without request");

    a_ack_err_excl: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !(o_wb_ack && o_wb_err))
        else $error("ack and err together");

    a_dat_idle_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !o_wb_ack
        |-> o_wb_dat == data_zero)
        else $error("read data outside ack");

    a_read_data: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (req && bus.hit && !i_wb_we)
        |=> o_wb_ack && o_wb_dat == $past(bus.rdata))
        else $error("read data wrong");

    a_read_miss_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (req && !bus.hit && !i_wb_we)
        |=> o_wb_dat == data_zero)
        else $error("unmapped read not zero");

    a_write_once: assert property (@(posedge i_core_clk) disable iff (i_rst)
        bus.write
        |=> !bus.write)
        else $error("held strobe wrote twice");

    a_miss_regs_stable: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (req && !bus.hit)
        |=> $stable(regs[0]) && $stable(regs[1]) && $stable(regs[2])
            && $stable(regs[3]) && $stable(regs[4]) && $stable(regs[5]))
        else $error("unmapped write changed a register");

    // register writes
    a_yc_write: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (bus.write && i_wb_adr == off_yc_to_rgb_set_zero && i_wb_sel == 4'hf)
        |=> regs[1] == $past(i_wb_dat))
        else $error("luma coefficient write lost");

    a_yc_one_mask: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (bus.write && i_wb_adr == off_yc_to_rgb_set_one && i_wb_sel == 4'hf)
        |=> regs[2] == ($past(i_wb_dat) & mask_yc_to_rgb_set_one))
        else $error("second luma set mask wrong");

    a_rgb_zero_mask: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (bus.write && i_wb_adr == off_rgb_to_yc_set_zero && i_wb_sel == 4'hf)
        |=> regs[3] == ($past(i_wb_dat) & mask_rgb_to_yc))
        else $error("first rgb set mask wrong");

    a_rgb_one_mask: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (bus.write && i_wb_adr == off_rgb_to_yc_set_one && i_wb_sel == 4'hf)
        |=> regs[4] == ($past(i_wb_dat) & mask_rgb_to_yc))
        else $error("second rgb set mask wrong");

    a_rgb_two_mask: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (bus.write && i_wb_adr == off_rgb_to_yc_set_two && i_wb_sel == 4'hf)
        |=> regs[5] == ($past(i_wb_dat) & mask_rgb_to_yc))
        else $error("third rgb set mask wrong");

    a_base_lane_keep: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (bus.write && i_wb_adr == off_codec_buffer_base && !i_wb_sel[3])
        |=> regs[0][data_width-1 -: coef_width] == $past(regs[0][data_width-1 -: coef_width]))
        else $error("unselected base lane changed");

    a_rgb_lane_keep: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (bus.write && i_wb_adr == off_rgb_to_yc_set_zero && !i_wb_sel[0])
        |=> regs[3][coef_width-1:0] == $past(regs[3][coef_width-1:0]))
        else $error("unselected coefficient lane changed");

    a_reserved_high: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (regs[4] & ~mask_rgb_to_yc) == data_zero
        && (regs[5] & ~mask_rgb_to_yc) == data_zero)
        else $error("reserved bits set in last sets");

    // conversion views
    a_base_follow: assert property (@(posedge i_core_clk) disable iff (i_rst)
        1'b1
        |=> o_codec_buffer_base == $past(regs[0]))
        else $error("base view wrong");

    a_yc_set_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
        1'b1
        |=> {o_yc_coef[3], o_yc_coef[2], o_yc_coef[1], o_yc_coef[0]} == $past(regs[1]))
        else $error("luma coefficient view wrong");

    a_rgb_set_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
        1'b1
        |=> {o_rgb_coef[2], o_rgb_coef[1], o_rgb_coef[0]}
            == $past(regs[3][3*coef_width-1:0]))
        else $error("first rgb coefficient view wrong");

    a_rgb_set_one: assert property (@(posedge i_core_clk) disable iff (i_rst)
        1'b1
        |=> {o_rgb_coef[5], o_rgb_coef[4], o_rgb_coef[3]}
            == $past(regs[4][3*coef_width-1:0]))
        else $error("second rgb coefficient view wrong");

    a_rgb_set_two: assert property (@(posedge i_core_clk) disable iff (i_rst)
        1'b1
        |=> {o_rgb_coef[8], o_rgb_coef[7], o_rgb_coef[6]}
            == $past(regs[5][3*coef_width-1:0]))
        else $error("third rgb coefficient view wrong");

    // offset selects
    a_y_offset_off: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !regs[2][pos_y_offset]
        |=> o_y_offset == offset_none)
        else $error("luma offset not cleared");

    a_cr_offset_on: assert property (@(posedge i_core_clk) disable iff (i_rst)
        regs[2][pos_cr_offset]
        |=> o_cr_offset == offset_small)
        else $error("red chroma offset missing");

    a_cb_offset_on: assert property (@(posedge i_core_clk) disable iff (i_rst)
        regs[2][pos_cb_offset]
        |=> o_cb_offset == offset_small)
        else $error("blue chroma offset missing");

    a_cb_offset_off: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !regs[2][pos_cb_offset]
        |=> o_cb_offset == offset_none)
        else $error("blue chroma offset not cleared");

    a_r_offset_on: assert property (@(posedge i_core_clk) disable iff (i_rst)
        regs[3][pos_comp_offset]
        |=> o_r_offset == offset_small)
        else $error("red offset missing");

    a_r_offset_off: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !regs[3][pos_comp_offset]
        |=> o_r_offset == offset_none)
        else $error("red offset not cleared");

    a_g_offset_off: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !regs[4][pos_comp_offset]
        |=> o_g_offset == offset_none)
        else $error("green offset not cleared");

    a_b_offset_on: assert property (@(posedge i_core_clk) disable iff (i_rst)
        regs[5][pos_comp_offset]
        |=> o_b_offset == offset_large)
        else $error("blue offset missing");

    a_b_offset_off: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !regs[5][pos_comp_offset]
        |=> o_b_offset == offset_none)
        else $error("blue offset not cleared");

    // reset values, checked the cycle after reset is seen
    a_reset_bus: assert property (@(posedge i_core_clk)
        i_rst
        |=> !o_wb_ack && !o_wb_err && o_wb_dat == data_zero)
        else $error("bus outputs not cleared by reset");

    a_reset_regs: assert property (@(posedge i_core_clk)
        i_rst
        |=> regs[0] == rst_codec_buffer_base && regs[1] == rst_yc_to_rgb_set_zero
            && regs[2] == rst_yc_to_rgb_set_one && regs[3] == rst_rgb_to_yc_set_zero
            && regs[4] == rst_rgb_to_yc_set_one && regs[5] == rst_rgb_to_yc_set_two)
        else $error("registers not at reset values");

    a_reset_views: assert property (@(posedge i_core_clk)
        i_rst
        |=> o_codec_buffer_base == rst_codec_buffer_base && o_y_offset == offset_none
            && o_g_offset == offset_none && o_yc_coef4_msb == 1'b0)
        else $error("views not cleared by reset");

    // scenario covers
    c_write: cover property (@(posedge i_core_clk) bus.write ##1 o_wb_ack);
    c_read: cover property (@(posedge i_core_clk) (req && !i_wb_we && bus.hit) ##1 o_wb_ack);
    c_err: cover property (@(posedge i_core_clk) o_wb_err);
    c_partial_write: cover property (@(posedge i_core_clk) bus.write && i_wb_sel != 4'hf);
    c_reset_then_read: cover property (@(posedge i_core_clk) $fell(i_rst) ##[1:20] o_wb_ack);
endmodule : image_color_space_coef_regs

/* image_color_space_coef_regs_tb.sv */
`timescale 1ns/1ps
module image_color_space_coef_regs_tb;
    import csc_regs_pkg::*;
    localparam logic [7:0] offs [6] = '{off_codec_buffer_base, off_yc_to_rgb_set_zero,
        off_yc_to_rgb_set_one, off_rgb_to_yc_set_zero, off_rgb_to_yc_set_one,
        off_rgb_to_yc_set_two};
    localparam logic [31:0] rstv [6] = '{rst_codec_buffer_base, rst_yc_to_rgb_set_zero,
        rst_yc_to_rgb_set_one, rst_rgb_to_yc_set_zero, rst_rgb_to_yc_set_one,
        rst_rgb_to_yc_set_two};
    localparam logic [31:0] msk [6] = '{mask_all, mask_all, mask_yc_to_rgb_set_one,
        mask_rgb_to_yc, mask_rgb_to_yc, mask_rgb_to_yc};
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat, base, rd, d;
    logic ack, err, ymsb, e;
    logic [7:0] yc [5];
    logic [7:0] rgb [9];
    logic [7:0] yoff, croff, cboff, roff, goff, boff;
    logic [31:0] m [6];
    logic [31:0] seed = 32'h492a;
    int n_errors = 0;
    int total_checks = 0;
    int idx;

    always #20 i_core_clk = ~i_core_clk;

    image_color_space_coef_regs dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
        .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_wb_err(err),
        .o_codec_buffer_base(base), .o_yc_coef(yc), .o_yc_coef4_msb(ymsb),
        .o_y_offset(yoff), .o_cr_offset(croff), .o_cb_offset(cboff), .o_rgb_coef(rgb),
        .o_r_offset(roff), .o_g_offset(goff), .o_b_offset(boff));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // one classic cycle; waits for ack or err, then idles one cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
        input logic [31:0] dd);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= dd;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        if (n >= 20) n_errors++;
        rd = rdat;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge i_core_clk);
    endtask : wb

    task automatic model_write(input int i, input logic [3:0] s, input logic [31:0] dd);
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                m[i][8*b+:8] = (m[i][8*b+:8] & ~msk[i][8*b+:8])
                    | (dd[8*b+:8] & msk[i][8*b+:8]);
            end
        end
    endtask : model_write

    task automatic check_views;
        chk(base, m[0]);
        for (int i = 0; i < 4; i++) chk(32'(yc[i]), 32'(m[1][8*i+:8]));
        chk(32'({ymsb, yc[4]}), 32'(m[2][8:0]));
        chk(32'(yoff), 32'(m[2][pos_y_offset] ? offset_large : offset_none));
        chk(32'(croff), 32'(m[2][pos_cr_offset] ? offset_small : offset_none));
        chk(32'(cboff), 32'(m[2][pos_cb_offset] ? offset_small : offset_none));
        for (int k = 0; k < 3; k++) chk(32'(rgb[k]), 32'(m[3][8*k+:8]));
        chk(32'(roff), 32'(m[3][24] ? offset_small : offset_none));
        for (int k = 0; k < 3; k++) chk(32'(rgb[3+k]), 32'(m[4][8*k+:8]));
        chk(32'(goff), 32'(m[4][24] ? offset_large : offset_none));
        for (int k = 0; k < 3; k++) chk(32'(rgb[6+k]), 32'(m[5][8*k+:8]));
        chk(32'(boff), 32'(m[5][24] ? offset_large : offset_none));
    endtask : check_views

    task automatic finish_test;
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (5000) @(posedge i_core_clk);
        n_errors++;
        finish_test();
    end

    initial begin
        for (int i = 0; i < 6; i++) m[i] = rstv[i];
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(posedge i_core_clk);
        for (int i = 0; i < 6; i++) begin
            wb(1'b0, offs[i], 4'hf, 32'h0000_0000);
            chk(rd, rstv[i]);
        end
        check_views();
        // all ones, all zeros, then random data and lane enables
        for (int t = 0; t < 60; t++) begin
            seed = lfsr(seed);
            idx = (t < 12) ? t % 6 : int'(seed[7:0]) % 6;
            d = (t < 6) ? 32'hffff_ffff : (t < 12) ? 32'h0000_0000 : lfsr(seed);
            wb(1'b1, offs[idx], (t < 12) ? 4'hf : seed[11:8], d);
            model_write(idx, (t < 12) ? 4'hf : seed[11:8], d);
            wb(1'b0, offs[idx], 4'hf, 32'h0000_0000);
            chk(rd, m[idx]);
            check_views();
        end
        wb(1'b1, 8'h18, 4'hf, 32'hffff_ffff);
        chk(32'(e), 32'h0000_0001);
        wb(1'b0, 8'hfc, 4'hf, 32'h0000_0000);
        chk(rd, data_zero);
        check_views();
        // second reset in mid-run restores defaults
        i_rst <= 1'b1;
        @(posedge i_core_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        for (int i = 0; i < 6; i++) m[i] = rstv[i];
        check_views();
        for (int i = 0; i < 6; i++) begin
            wb(1'b0, offs[i], 4'hf, 32'h0000_0000);
            chk(rd, rstv[i]);
        end
        finish_test();
    end
endmodule : image_color_space_coef_regs_tb
